/* shared/nipc_defs.svh */
// Purpose: constants for the nested interrupt priority controller
// Assumes: wishbone word addressing, 8-bit data in the low lane
// Notes: included by the package and the design files
`ifndef NIPC_DEFS_SVH
`define NIPC_DEFS_SVH

`define NIPC_ADR_W 4
`define NIPC_OFF_VP0 4'h0
`define NIPC_OFF_VP1 4'h1
`define NIPC_OFF_VP2 4'h2
`define NIPC_OFF_VP3 4'h3
`define NIPC_OFF_CCF 4'h4
`define NIPC_OFF_STAT 4'h5
`define NIPC_OFF_PEND 4'h6
`define NIPC_OFF_PENH 4'h7
`define NIPC_OFF_ENA 4'h8
`define NIPC_OFF_ENAH 4'h9

`define NIPC_NSRC 13
`define NIPC_SRC_W 4
`define NIPC_VP_RST 8'hff
`define NIPC_VP3_RO 8'hf0
// unknown flag bit four taken as zero
`define NIPC_CC_RST 8'hea
`define NIPC_BIT_PH 5
`define NIPC_BIT_PL 3
`define NIPC_LVL_W 2
`define NIPC_CODE_L0 2'b10
`define NIPC_CODE_L3 2'b11

`define NIPC_VEC_RESET 16'hfffe
`define NIPC_VEC_TRAP 16'hfffc
`define NIPC_VEC_SRC0 16'hfffa
`define NIPC_VEC_STEP 16'h0002

`define NIPC_WAKE_HALT 13'h001c
`define NIPC_WAKE_AWU 13'h0001
`define NIPC_WAKE_ACT 13'h0480

`endif

/* shared/nipc_pkg.sv */
// Purpose: types for the nested interrupt priority controller
// Assumes: constants come from nipc_defs.svh
// Notes: none
`include "nipc_defs.svh"
package nipc_pkg;
  typedef enum logic [2:0] {
    NIPC_OP_NONE,
    NIPC_OP_ENABLE,
    NIPC_OP_DISABLE,
    NIPC_OP_WAIT,
    NIPC_OP_HALT,
    NIPC_OP_POPCC,
    NIPC_OP_RETURN_FROM_IRQ_INSTR,
    NIPC_OP_TRAP
  } nipc_op_t;
  typedef enum logic [1:0] {
    NIPC_PM_RUN,
    NIPC_PM_HALT,
    NIPC_PM_ACTIVE,
    NIPC_PM_AWU
  } nipc_pmode_t;
endpackage

/* src/nipc_prio_regs.sv */
// Purpose: the four vector priority registers
// Assumes: one write port, registered read port
// Notes: level-0 pairs in a write keep the old pair
`timescale 1ns/100ps
`default_nettype none
`include "nipc_defs.svh"
module nipc_prio_regs
  import nipc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [1:0] wr_idx,
  input wire logic [7:0] wr_data,
  input wire logic [1:0] rd_idx,
  output logic [7:0] rd_data,
  output logic [4*8-1:0] flat
);
  logic [7:0] vp [0:3];

  // merge a write, keeping pairs that would be level 0
  function automatic logic [7:0] merge(input logic [7:0] old_v,
                                       input logic [7:0] new_v);
    logic [7:0] r;
    r = new_v;
    for (int i = 0; i < 4; i++) begin
      if (new_v[2*i +: 2] == `NIPC_CODE_L0) begin
        r[2*i +: 2] = old_v[2*i +: 2]; // [RULE_08]
      end
    end
    return r;
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        vp[i] <= `NIPC_VP_RST; // [RULE_05]
      end
    end else if (wr_en) begin
      if (wr_idx == 2'd3) begin
        vp[3] <= merge(vp[3], wr_data) | `NIPC_VP3_RO; // [RULE_05]
      end else begin
        vp[wr_idx] <= merge(vp[wr_idx], wr_data);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= `NIPC_VP_RST;
    end else begin
      rd_data <= vp[rd_idx];
    end
  end

  assign flat = {vp[3], vp[2], vp[1], vp[0]};
endmodule
`default_nettype wire

/* src/nipc_top.sv */
// Purpose: nested interrupt priority control for an 8-bit cpu core
// Assumes: cpu reports instructions as one-cycle pulses on OP_VALID
// Notes: wishbone classic slave, ack one cycle after the strobe
// Behaviour
// [RULE_01] priority held in flag bits five, three
// [RULE_02] entry loads vector pair into priority bits
// [RULE_03] reset and trap taken at level three
// [RULE_04] codes: 10 lowest, 01, 00, 11 disabled
// [RULE_05] priority registers reset ones, top nibble fixed
// [RULE_06] two-bit pair per vector, four per register
// [RULE_07] reset and trap set level three
// [RULE_08] level-zero pair writes keep old pair
// [RULE_09] own-routine change re-enters only if higher
// [RULE_10] enable, wait, halt load code 10
// [RULE_11] disable and trap load code 11
// [RULE_12] return and pop restore whole flag register
// [RULE_13] level-test branches compare bits with 11
// [RULE_14] instruction changes persist until next such
// [RULE_15] fixed vector addresses, priority falls with number
// [RULE_16] thirteen sources in fixed order
// [RULE_17] only external lines wake from full halt
// [RULE_18] auto-wakeup source wakes only auto mode
// [RULE_19] sources seven, ten wake only active halt
// [RULE_20] serviced only if enabled and higher priority
// [RULE_21] highest software priority first, ties by number
`timescale 1ns/100ps
`default_nettype none
`include "nipc_defs.svh"
module nipc_top
  import nipc_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [`NIPC_ADR_W-1:0] WB_ADR_I,
  input wire logic [7:0] WB_DAT_I,
  input wire logic WB_WE_I,
  input wire logic WB_SEL_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  output logic [7:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic [`NIPC_NSRC-1:0] IRQ_REQ,
  input wire logic [`NIPC_NSRC-1:0] IRQ_CLR,
  input wire logic OP_VALID,
  input wire nipc_op_t OP_CODE,
  input wire logic [7:0] OP_STACK_CC,
  input wire logic [1:0] PWR_MODE,
  input wire logic TAKE_ACK,
  output logic TAKE_REQ,
  output logic [15:0] TAKE_VECTOR,
  output logic [`NIPC_SRC_W-1:0] TAKE_SRC,
  output logic TAKE_NMI,
  output logic [7:0] CC_FLAGS,
  output logic BRANCH_MASKED,
  output logic BRANCH_UNMASKED,
  output logic WAKE
);
  logic [7:0] condition_code_flags;
  logic [`NIPC_NSRC-1:0] pending;
  logic [`NIPC_NSRC-1:0] enable;
  logic [4*8-1:0] vp_flat;
  logic [`NIPC_NSRC-1:0] pending_q;
  logic bus_req;
  logic bus_wr;
  logic bus_rd;
  logic vp_sel;
  logic trap_pend;
  logic in_service;
  logic [`NIPC_SRC_W-1:0] serv_src;
  logic [1:0] serv_entry_pair;
  logic cand_ok;
  logic [`NIPC_SRC_W-1:0] cand_src;
  logic [1:0] cand_rank;
  logic [`NIPC_NSRC-1:0] wake_mask;
  nipc_pmode_t pmode;

  // ************************************************************
  // priority helpers
  // ************************************************************
  // code to rank, larger is higher priority
  function automatic logic [1:0] rank(input logic [1:0] code);
    case (code) // [RULE_04]
      2'b10: rank = 2'd0;
      2'b01: rank = 2'd1;
      2'b00: rank = 2'd2;
      default: rank = 2'd3;
    endcase
  endfunction

  function automatic logic [1:0] pair_of(input logic [31:0] f,
                                         input logic [3:0] s);
    pair_of = f[{s, 1'b0} +: 2]; // [RULE_06]
  endfunction

  function automatic logic [1:0] cur_code(input logic [7:0] cc);
    cur_code = {cc[`NIPC_BIT_PH], cc[`NIPC_BIT_PL]}; // [RULE_01]
  endfunction

  function automatic logic [7:0] set_code(input logic [7:0] cc,
                                          input logic [1:0] c);
    logic [7:0] r;
    r = cc;
    r[`NIPC_BIT_PH] = c[1];
    r[`NIPC_BIT_PL] = c[0];
    return r;
  endfunction

  // ************************************************************
  // wishbone slave
  // ************************************************************
  // ack drops the cycle after it is given, so a request is taken once
  assign bus_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign bus_wr = bus_req && WB_WE_I && WB_SEL_I;
  assign bus_rd = bus_req && !WB_WE_I;
  assign vp_sel = (WB_ADR_I <= `NIPC_OFF_VP3);

  nipc_prio_regs u_regs (
    .clk(MCLK),
    .rst_n(RST_N),
    .wr_en(bus_wr && vp_sel),
    .wr_idx(WB_ADR_I[1:0]),
    .wr_data(WB_DAT_I),
    .rd_idx(WB_ADR_I[1:0]),
    .rd_data(),
    .flat(vp_flat)
  );

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      WB_ACK_O <= 1'b0;
    end else begin
      WB_ACK_O <= bus_req;
    end
  end

  // ************************************************************
  // register read
  // ************************************************************
  // status: entry pair, in service, serviced source
  function automatic logic [7:0] reg_read(
    input logic [`NIPC_ADR_W-1:0] a,
    input logic [4*8-1:0] vp,
    input logic [7:0] cc,
    input logic [7:0] stat,
    input logic [`NIPC_NSRC-1:0] pend,
    input logic [`NIPC_NSRC-1:0] ena
  );
    case (a)
      `NIPC_OFF_VP0: reg_read = vp[7:0];
      `NIPC_OFF_VP1: reg_read = vp[15:8];
      `NIPC_OFF_VP2: reg_read = vp[23:16];
      `NIPC_OFF_VP3: reg_read = vp[31:24];
      `NIPC_OFF_CCF: reg_read = cc;
      `NIPC_OFF_STAT: reg_read = stat;
      `NIPC_OFF_PEND: reg_read = pend[7:0];
      `NIPC_OFF_PENH: reg_read = {3'h0, pend[12:8]};
      `NIPC_OFF_ENA: reg_read = ena[7:0];
      `NIPC_OFF_ENAH: reg_read = {3'h0, ena[12:8]};
      default: reg_read = 8'h00;
    endcase
  endfunction

  // read data registered with the acknowledge, zero otherwise
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      WB_DAT_O <= 8'h00;
    end else if (bus_rd) begin
      WB_DAT_O <= reg_read(WB_ADR_I, vp_flat, condition_code_flags,
        {1'b0, serv_entry_pair, in_service, serv_src}, pending_q, enable);
    end else begin
      WB_DAT_O <= 8'h00;
    end
  end

  // status copy of the pending latches, one cycle behind
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      pending_q <= '0;
    end else begin
      pending_q <= pending;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      enable <= '0;
    end else if (bus_wr && WB_ADR_I == `NIPC_OFF_ENA) begin
      enable[7:0] <= WB_DAT_I;
    end else if (bus_wr && WB_ADR_I == `NIPC_OFF_ENAH) begin
      enable[12:8] <= WB_DAT_I[4:0];
    end
  end

  // ************************************************************
  // pending latches
  // ************************************************************
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      pending <= '0;
    end else begin
      // new request wins over a clear in the same cycle
      pending <= (pending & ~IRQ_CLR) | IRQ_REQ; // [RULE_20]
    end
  end

  // a new trap wins over the acknowledge of the last one
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      trap_pend <= 1'b0;
    end else if (OP_VALID && OP_CODE == NIPC_OP_TRAP) begin
      trap_pend <= 1'b1;
    end else if (TAKE_REQ && TAKE_ACK && TAKE_NMI) begin
      trap_pend <= 1'b0;
    end
  end

  // ************************************************************
  // arbitration
  // ************************************************************
  always_comb begin
    wake_mask = `NIPC_WAKE_HALT; // [RULE_17]
    case (pmode)
      NIPC_PM_AWU: wake_mask = `NIPC_WAKE_HALT | `NIPC_WAKE_AWU; // [RULE_18]
      NIPC_PM_ACTIVE: wake_mask = `NIPC_WAKE_HALT | `NIPC_WAKE_ACT; // [RULE_19]
      // run mode lets every source through
      NIPC_PM_RUN: wake_mask = '1;
      default: wake_mask = `NIPC_WAKE_HALT;
    endcase
  end

  assign pmode = nipc_pmode_t'(PWR_MODE);

  // lowest number wins ties: scan downward, keep strictly higher or equal
  always_comb begin
    logic [1:0] r;
    logic [1:0] cur;
    r = 2'd0;
    cur = rank(cur_code(condition_code_flags));
    cand_ok = 1'b0;
    cand_src = '0;
    cand_rank = 2'd0;
    for (int i = `NIPC_NSRC-1; i >= 0; i--) begin // [RULE_16]
      r = rank(pair_of(vp_flat, i[3:0])); // [RULE_09]
      if (pending[i] && enable[i] && wake_mask[i] && r > cur // [RULE_20]
          && (!cand_ok || r >= cand_rank)) begin // [RULE_21]
        cand_ok = 1'b1;
        cand_src = i[3:0];
        cand_rank = r;
      end
    end
  end

  // ************************************************************
  // service request to the core
  // ************************************************************
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      TAKE_REQ <= 1'b0;
      TAKE_NMI <= 1'b0;
      TAKE_SRC <= '0;
      TAKE_VECTOR <= `NIPC_VEC_RESET; // [RULE_15]
    end else if (TAKE_REQ && TAKE_ACK) begin
      TAKE_REQ <= 1'b0;
    end else if (!TAKE_REQ && trap_pend) begin
      TAKE_REQ <= 1'b1; // [RULE_03]
      TAKE_NMI <= 1'b1;
      TAKE_VECTOR <= `NIPC_VEC_TRAP; // [RULE_15]
    end else if (!TAKE_REQ && cand_ok) begin
      TAKE_REQ <= 1'b1;
      TAKE_NMI <= 1'b0;
      TAKE_SRC <= cand_src;
      TAKE_VECTOR <= `NIPC_VEC_SRC0 -
        ({12'h000, cand_src} * `NIPC_VEC_STEP); // [RULE_15]
    end
  end

  // pending stays set after entry, the source must clear it
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      in_service <= 1'b0;
      serv_src <= '0;
      serv_entry_pair <= `NIPC_CODE_L3;
    end else if (TAKE_REQ && TAKE_ACK && !TAKE_NMI) begin
      in_service <= 1'b1;
      serv_src <= TAKE_SRC;
      serv_entry_pair <= pair_of(vp_flat, TAKE_SRC);
    end else if (OP_VALID && OP_CODE == NIPC_OP_RETURN_FROM_IRQ_INSTR) begin
      in_service <= 1'b0;
    end
  end

  // ************************************************************
  // condition code flags
  // ************************************************************
  // reset leaves level 3 in the priority bits
  // an instruction in an acknowledge cycle is dropped
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      condition_code_flags <= `NIPC_CC_RST; // [RULE_07]
    end else if (TAKE_REQ && TAKE_ACK) begin
      if (TAKE_NMI) begin
        condition_code_flags <= set_code(condition_code_flags,
                                         `NIPC_CODE_L3); // [RULE_07]
      end else begin
        condition_code_flags <= set_code(condition_code_flags,
          pair_of(vp_flat, TAKE_SRC)); // [RULE_02]
      end
    end else if (OP_VALID) begin
      case (OP_CODE) // [RULE_14]
        NIPC_OP_ENABLE, NIPC_OP_WAIT, NIPC_OP_HALT:
          condition_code_flags <= set_code(condition_code_flags,
                                           `NIPC_CODE_L0); // [RULE_10]
        NIPC_OP_DISABLE, NIPC_OP_TRAP:
          condition_code_flags <= set_code(condition_code_flags,
                                           `NIPC_CODE_L3); // [RULE_11]
        NIPC_OP_POPCC, NIPC_OP_RETURN_FROM_IRQ_INSTR:
          condition_code_flags <= OP_STACK_CC; // [RULE_12]
        default: condition_code_flags <= condition_code_flags;
      endcase
    end
  end

  // re-entry of own source follows the arbiter, which sees the new pair
  // only raising the pair past the current level lets it win [RULE_09]

  // ************************************************************
  // registered outputs
  // ************************************************************
  // branch flags follow the level one cycle late
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      CC_FLAGS <= `NIPC_CC_RST;
      BRANCH_MASKED <= 1'b1;
      BRANCH_UNMASKED <= 1'b0;
      WAKE <= 1'b0;
    end else begin
      CC_FLAGS <= condition_code_flags;
      BRANCH_MASKED <= cur_code(condition_code_flags)
                       == `NIPC_CODE_L3; // [RULE_13]
      BRANCH_UNMASKED <= cur_code(condition_code_flags)
                         != `NIPC_CODE_L3; // [RULE_13]
      WAKE <= |(pending & enable & wake_mask) || trap_pend;
    end
  end
endmodule
`default_nettype wire

/* verification/nipc_cpu_model.sv */
// Purpose: cpu core side of the service handshake
// Assumes: TAKE_REQ is held until acknowledged
// Notes: slow inserts a wait before the acknowledge
`timescale 1ns/100ps
`default_nettype none
module nipc_cpu_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic take_req,
  output logic take_ack
);
  logic [3:0] wait_cnt;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      take_ack <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (take_ack || !take_req) begin
      take_ack <= 1'b0;
      wait_cnt <= 4'h0;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
      take_ack <= !slow || wait_cnt == 4'h6;
    end
  end
endmodule
`default_nettype wire

/* verification/nipc_top_chk.sv */
// Purpose: port assertions for nipc_top
// Assumes: one clock, async active-low reset
// Notes: bound to every nipc_top
`timescale 1ns/100ps
`default_nettype none
module nipc_top_chk
  import nipc_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [3:0] WB_ADR_I,
  input wire logic WB_WE_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic [7:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic OP_VALID,
  input wire nipc_op_t OP_CODE,
  input wire logic [7:0] OP_STACK_CC,
  input wire logic TAKE_ACK,
  input wire logic TAKE_REQ,
  input wire logic [15:0] TAKE_VECTOR,
  input wire logic [3:0] TAKE_SRC,
  input wire logic TAKE_NMI,
  input wire logic [7:0] CC_FLAGS,
  input wire logic BRANCH_MASKED,
  input wire logic BRANCH_UNMASKED
);
  // ****
  // helpers and assertions
  // ****
  logic [7:0] popped;
  logic [1:0] lvl;
  assign lvl = {CC_FLAGS[5], CC_FLAGS[3]};
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      popped <= 8'h00;
    end else if (OP_VALID) begin
      popped <= OP_STACK_CC;
    end
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (
    WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("no ack after strobe");
  a_unmapped_zero: assert property (
    WB_ACK_O && !WB_WE_I && WB_ADR_I > 4'h9 |-> WB_DAT_O == 8'h00)
    else $error("unmapped read not zero");
  a_vp3_top_ones: assert property (
    WB_ACK_O && !WB_WE_I && WB_ADR_I == 4'h3 |-> WB_DAT_O[7:4] == 4'hf)
    else $error("fixed nibble not ones");
  a_enable_code: assert property (
    OP_VALID && OP_CODE inside {NIPC_OP_ENABLE, NIPC_OP_WAIT, NIPC_OP_HALT}
    |-> ##[1:2] lvl == 2'b10)
    else $error("level zero code not loaded");
  a_disable_code: assert property (
    OP_VALID && OP_CODE inside {NIPC_OP_DISABLE, NIPC_OP_TRAP}
    |-> ##[1:2] lvl == 2'b11)
    else $error("level three code not loaded");
  a_pop_restore: assert property (
    OP_VALID && OP_CODE inside {NIPC_OP_POPCC, NIPC_OP_RETURN_FROM_IRQ_INSTR}
    |-> ##[1:2] CC_FLAGS == popped)
    else $error("flags not restored");
  a_branch_pair: assert property (
    BRANCH_MASKED != BRANCH_UNMASKED)
    else $error("branch conditions not complementary");
  a_vector_map: assert property (
    TAKE_REQ && !TAKE_NMI |-> TAKE_VECTOR + {TAKE_SRC, 1'b0} == 16'hfffa)
    else $error("vector does not match source");
  a_trap_entry: assert property (
    TAKE_REQ && TAKE_ACK && TAKE_NMI
    |-> TAKE_VECTOR == 16'hfffc ##[1:2] lvl == 2'b11)
    else $error("trap entry wrong");
  a_req_holds: assert property (
    TAKE_REQ && !TAKE_ACK |=> TAKE_REQ && $stable(TAKE_VECTOR))
    else $error("request dropped or changed");
endmodule
bind nipc_top nipc_top_chk u_nipc_top_chk (.MCLK(MCLK), .RST_N(RST_N),
  .WB_ADR_I(WB_ADR_I), .WB_WE_I(WB_WE_I), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
  .OP_VALID(OP_VALID), .OP_CODE(OP_CODE), .OP_STACK_CC(OP_STACK_CC),
  .TAKE_ACK(TAKE_ACK), .TAKE_REQ(TAKE_REQ), .TAKE_VECTOR(TAKE_VECTOR),
  .TAKE_SRC(TAKE_SRC), .TAKE_NMI(TAKE_NMI), .CC_FLAGS(CC_FLAGS),
  .BRANCH_MASKED(BRANCH_MASKED), .BRANCH_UNMASKED(BRANCH_UNMASKED));
`default_nettype wire

/* verification/tb_nipc_top.sv */
// Purpose: self-checking bench for nipc_top
// Assumes: cpu model answers service requests
// Notes: lfsr stimulus from a fixed seed
`timescale 1ns/100ps
`default_nettype none
module tb_nipc_top import nipc_pkg::*;;
  logic MCLK = 1'b0;
  logic RST_N = 1'b0;
  logic [3:0] WB_ADR_I, TAKE_SRC;
  logic [7:0] WB_DAT_I, WB_DAT_O, OP_STACK_CC, CC_FLAGS, q;
  logic WB_WE_I, WB_SEL_I, WB_CYC_I, WB_STB_I, WB_ACK_O, OP_VALID;
  logic TAKE_ACK, TAKE_REQ, TAKE_NMI, BRANCH_MASKED, BRANCH_UNMASKED;
  logic WAKE, slow;
  logic [12:0] IRQ_REQ, IRQ_CLR;
  logic [1:0] PWR_MODE;
  logic [15:0] TAKE_VECTOR;
  nipc_op_t OP_CODE;
  int err_total, check_count, cycles, i;
  logic [16:0] lfsr = 17'h181c4;
  logic [7:0] shadow [4];
  nipc_op_t ens [3] = '{NIPC_OP_ENABLE, NIPC_OP_WAIT, NIPC_OP_HALT};
  // wake table: mode, source, expected
  logic [6:0] wt [8] = '{7'h25, 7'h22, 7'h2e, 7'h20,
    7'h61, 7'h4f, 7'h55, 7'h52};
  always #2.5 MCLK = ~MCLK;
  nipc_top u_nipc_top (.MCLK(MCLK), .RST_N(RST_N), .WB_ADR_I(WB_ADR_I),
    .WB_DAT_I(WB_DAT_I), .WB_WE_I(WB_WE_I), .WB_SEL_I(WB_SEL_I),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O),
    .WB_ACK_O(WB_ACK_O), .IRQ_REQ(IRQ_REQ), .IRQ_CLR(IRQ_CLR),
    .OP_VALID(OP_VALID), .OP_CODE(OP_CODE), .OP_STACK_CC(OP_STACK_CC),
    .PWR_MODE(PWR_MODE), .TAKE_ACK(TAKE_ACK), .TAKE_REQ(TAKE_REQ),
    .TAKE_VECTOR(TAKE_VECTOR), .TAKE_SRC(TAKE_SRC), .TAKE_NMI(TAKE_NMI),
    .CC_FLAGS(CC_FLAGS), .BRANCH_MASKED(BRANCH_MASKED),
    .BRANCH_UNMASKED(BRANCH_UNMASKED), .WAKE(WAKE));
  nipc_cpu_model u_nipc_cpu_model (.clk(MCLK), .rst_n(RST_N),
    .slow(slow), .take_req(TAKE_REQ), .take_ack(TAKE_ACK));
  // ****
  // helpers
  // ****
  function logic [16:0] nxt(input logic [16:0] v);
    return {v[15:0], v[16] ^ v[13]};
  endfunction
  function logic [7:0] merge(input logic [7:0] o, input logic [7:0] n);
    logic [7:0] r;
    r = n;
    for (int k = 0; k < 8; k += 2) begin
      if (n[k+:2] == 2'b10) r[k+:2] = o[k+:2];
    end
    return r;
  endfunction
  function logic [1:0] lvl();
    return {CC_FLAGS[5], CC_FLAGS[3]};
  endfunction
  task chk(input string n, input logic [15:0] seen, input logic [15:0] e);
    check_count++;
    if (seen !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", n, e, seen);
    end
  endtask
  task wb(input logic [3:0] a, input logic w, input logic [7:0] d);
    @(posedge MCLK);
    WB_ADR_I <= a;
    WB_WE_I <= w;
    WB_DAT_I <= d;
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    do @(posedge MCLK); while (WB_ACK_O !== 1'b1);
    q = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
  endtask
  task op(input nipc_op_t c, input logic [7:0] s);
    @(posedge MCLK);
    OP_VALID <= 1'b1;
    OP_CODE <= c;
    OP_STACK_CC <= s;
    @(posedge MCLK);
    OP_VALID <= 1'b0;
    repeat (3) @(posedge MCLK);
  endtask
  task pulse(input logic [12:0] r, input logic [12:0] c);
    @(posedge MCLK);
    IRQ_REQ <= r;
    IRQ_CLR <= c;
    @(posedge MCLK);
    IRQ_REQ <= '0;
    IRQ_CLR <= '0;
  endtask
  task take(input logic [15:0] v);
    while (TAKE_REQ !== 1'b1) @(posedge MCLK);
    chk("vector", TAKE_VECTOR, v);
    chk("nmi", TAKE_NMI, v == 16'hfffc);
    if (v != 16'hfffc) begin
      chk("source", TAKE_SRC, (16'hfffa - v) >> 1);
    end
    while (TAKE_REQ === 1'b1) @(posedge MCLK);
    repeat (2) @(posedge MCLK);
  endtask
  task results;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge MCLK) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      results;
    end
  end
  // ****
  // main sequence
  // ****
  initial begin
    {WB_ADR_I, WB_DAT_I, WB_WE_I, WB_CYC_I, WB_STB_I} = '0;
    {IRQ_REQ, IRQ_CLR, OP_VALID, OP_STACK_CC, PWR_MODE, slow} = '0;
    WB_SEL_I = 1'b1;
    OP_CODE = NIPC_OP_NONE;
    repeat (4) @(posedge MCLK);
    RST_N <= 1'b1;
    for (i = 0; i < 4; i++) begin
      wb(i[3:0], 1'b0, 8'h00);
      chk("prio reset", q, 8'hff);
      shadow[i] = 8'hff;
    end
    wb(4'h4, 1'b0, 8'h00);
    chk("cc reset", q, 8'hea);
    chk("masked", BRANCH_MASKED, 1'b1);
    $display("test reset done");
    wb(4'h1, 1'b1, 8'hcf);
    wb(4'h1, 1'b1, 8'h64);
    wb(4'h1, 1'b0, 8'h00);
    chk("level0 keep", q, 8'h44);
    shadow[1] = 8'h44;
    for (i = 0; i < 12; i++) begin
      repeat (10) lfsr = nxt(lfsr);
      wb({2'b00, lfsr[9:8]}, 1'b1, lfsr[7:0]);
      shadow[lfsr[9:8]] = merge(shadow[lfsr[9:8]], lfsr[7:0])
        | (lfsr[9:8] == 2'd3 ? 8'hf0 : 8'h00);
      wb({2'b00, lfsr[9:8]}, 1'b0, 8'h00);
      chk("prio rw", q, shadow[lfsr[9:8]]);
    end
    wb(4'hf, 1'b1, 8'h5a);
    wb(4'hf, 1'b0, 8'h00);
    chk("unmapped", q, 8'h00);
    $display("test registers done");
    for (i = 0; i < 3; i++) begin
      op(NIPC_OP_DISABLE, 8'h00);
      chk("disable", lvl(), 2'b11);
      op(ens[i], 8'h00);
      chk("enable", lvl(), 2'b10);
      chk("branch", {BRANCH_MASKED, BRANCH_UNMASKED}, 2'b01);
    end
    for (i = 0; i < 6; i++) begin
      repeat (10) lfsr = nxt(lfsr);
      op(i[0] ? NIPC_OP_RETURN_FROM_IRQ_INSTR : NIPC_OP_POPCC, lfsr[7:0]);
      chk("pop_flags_instr", CC_FLAGS, lfsr[7:0]);
    end
    $display("test instructions done");
    for (i = 0; i < 4; i++) wb(i[3:0], 1'b1, i == 0 ? 8'hdf : 8'hff);
    wb(4'h8, 1'b1, 8'hff);
    wb(4'h9, 1'b1, 8'h1f);
    op(NIPC_OP_ENABLE, 8'h00);
    pulse(13'h0004, '0);
    take(16'hfff6);
    chk("entry", lvl(), 2'b01);
    slow <= 1'b1;
    pulse(13'h0008, '0);
    take(16'hfff4);
    chk("nested", lvl(), 2'b11);
    pulse('0, 13'h1fff);
    pulse(13'h0008, '0);
    repeat (10) @(posedge MCLK);
    chk("held", TAKE_REQ, 1'b0);
    op(NIPC_OP_TRAP, 8'h00);
    take(16'hfffc);
    chk("trap", lvl(), 2'b11);
    pulse('0, 13'h1fff);
    pulse(13'h0054, '0);
    op(NIPC_OP_RETURN_FROM_IRQ_INSTR, 8'h20);
    take(16'hfff2);
    pulse('0, 13'h1fff);
    $display("test service done");
    for (i = 0; i < 8; i++) begin
      PWR_MODE <= wt[i][6:5];
      pulse(13'h0001 << wt[i][4:1], '0);
      repeat (3) @(posedge MCLK);
      chk("wake", WAKE, wt[i][0]);
      pulse('0, 13'h1fff);
    end
    $display("test wake done");
    results;
  end
endmodule
`default_nettype wire
